// [shared/drive_io_params.svh]
// register offsets, reset values and timing constants of the terminal conditioning block
`ifndef DRIVE_IO_PARAMS_SVH
`define DRIVE_IO_PARAMS_SVH
`define DTIO_OFS_OUTSEL 8'h00
`define DTIO_OFS_DELAY 8'h18
`define DTIO_OFS_RESP 8'h30
`define DTIO_OFS_PMON_SEL 8'h54
`define DTIO_OFS_PMON_GAIN 8'h58
`define DTIO_OFS_VMON_SEL 8'h5C
`define DTIO_OFS_IMON_SEL 8'h60
`define DTIO_OFS_VMON_GAIN 8'h64
`define DTIO_OFS_IMON_GAIN 8'h68
`define DTIO_OFS_VMON_OFS 8'h6C
`define DTIO_OFS_IMON_OFS 8'h70
`define DTIO_OFS_CUR_REF 8'h74
`define DTIO_OFS_CTRL_METHOD 8'h78
`define DTIO_OFS_STATUS 8'h7C
`define DTIO_DELAY_ON_LSB 0
`define DTIO_DELAY_OFF_LSB 16
`define DTIO_STATUS_IN_LSB 16
`define DTIO_FN_REVERSE 8'h34
`define DTIO_FN_FATAL 8'h35
`define DTIO_RST_OUTSEL 8'h00
`define DTIO_RST_RELAYSEL 8'h05
`define DTIO_RST_RESP 8'h01
`define DTIO_RST_GAIN 8'h64
`define DTIO_RST_VOFS 8'h00
`define DTIO_RST_IOFS 8'h14
`define DTIO_GAIN_MIN 8'h32
`define DTIO_GAIN_MAX 8'hC8
`define DTIO_OFS_MAX 8'h64
`define DTIO_DELAY_MAX 10'h3E8
`define DTIO_RESP_MAX 8'hC8
`define DTIO_CM_SLV 8'h03
`define DTIO_CM_ZSLV 8'h04
`define DTIO_CM_V2 8'h05
`define DTIO_CLK_NS 50
`define DTIO_DELAY_TICK_NS 100000000
`define DTIO_RESP_TICK_NS 2000000
`define DTIO_CUR_PULSE_HZ 1440
`define DTIO_TEMP_FS_C 200
`endif

// [shared/drive_io_pkg.sv]
// types shared by the terminal conditioning block
package drive_io_pkg;
  typedef struct packed {
    logic [9:0] off_dly;
    logic [9:0] on_dly;
  } delay_t;
  typedef struct packed {
    logic [15:0] out_freq;
    logic [15:0] shaft_freq;
    logic [15:0] current;
    logic [15:0] torque;
    logic [15:0] out_volt;
    logic [15:0] in_volt;
    logic [15:0] thermal;
    logic [15:0] ramp_freq;
    logic [15:0] motor_temp;
    logic [15:0] fin_temp;
    logic [15:0] current_amps;
  } monitor_t;
  typedef enum logic [7:0] {
    MON_FREQ = 8'h00, MON_CUR = 8'h01, MON_TORQUE = 8'h02, MON_DIG_FREQ = 8'h03,
    MON_OUT_VOLT = 8'h04, MON_IN_VOLT = 8'h05, MON_THERMAL = 8'h06, MON_RAMP = 8'h07,
    MON_CUR_PULSE = 8'h08, MON_MOTOR_TEMP = 8'h09, MON_FIN_TEMP = 8'h0A,
    MON_SIGNED_TORQUE = 8'h0B
  } mon_sel_t;
endpackage

// [verilog/drive_terminal_io_conditioning.sv]
// drive terminal conditioning: output delays, input filters, monitors, apb registers
`timescale 1ns/1ns
`include "drive_io_params.svh"
module drive_terminal_io_conditioning #(
  parameter int DELAY_TICK_CYC = `DTIO_DELAY_TICK_NS / `DTIO_CLK_NS,
  parameter int RESP_TICK_CYC = `DTIO_RESP_TICK_NS / `DTIO_CLK_NS,
  parameter logic [15:0] RATED_CURRENT = 16'h0064,
  parameter int N_OUT = 6,
  parameter int N_IN = 9
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  // drive state
  input wire logic i_run_reverse,
  input wire logic i_alarm,
  input wire logic [5:0] i_hw_trip,
  input wire logic [63:0] i_out_cond,
  input drive_io_pkg::monitor_t i_monitor,
  // input terminals
  input wire logic [7:0] i_multi_function_inputs,
  input wire logic i_forward_run_input,
  output logic [N_IN-1:0] o_filtered_inputs,
  // output terminals
  output logic [4:0] o_open_collector_outputs,
  output logic o_relay_output,
  output logic o_reverse_run_indicator,
  output logic o_fatal_fault_indicator,
  // monitors
  output logic o_pulse_monitor_terminal,
  output logic [15:0] o_voltage_monitor_output,
  output logic [15:0] o_current_monitor_output
);
  localparam int HALF_CYC = 1000000000 / (`DTIO_CLK_NS * 2 * `DTIO_CUR_PULSE_HZ);
  localparam logic [15:0] REF_MIN = 16'((32'(RATED_CURRENT) * 2) / 10);
  localparam logic [15:0] REF_MAX = 16'(32'(RATED_CURRENT) * 2);
  logic [7:0] out_sel [N_OUT];
  drive_io_pkg::delay_t dly [N_OUT];
  logic [7:0] resp [N_IN];
  logic [7:0] pmon_sel, pmon_gain, vmon_sel, imon_sel, vmon_gain, imon_gain, vmon_ofs, imon_ofs;
  logic [15:0] cur_ref;
  logic [7:0] ctrl_method;
  logic [N_OUT-1:0] cond, term;
  logic [N_IN-1:0] raw_in;
  logic [31:0] delay_tick_cnt, resp_tick_cnt;
  logic delay_tick, resp_tick, hit, wr;
  logic [31:0] next_rdata;
  logic fatal, vec_mode, sens_mode;
  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction
  function automatic logic [15:0] temp_level(input logic [15:0] t);
    logic [31:0] p;
    p = 32'(t) * 32'd327;
    if (t[15] || t == 16'h0000) temp_level = 16'h0000;
    else if (t >= 16'(`DTIO_TEMP_FS_C)) temp_level = 16'hFFFF;
    else temp_level = p[15:0];
  endfunction
  // selected quantity as a fraction of full scale
  function automatic logic [15:0] level(input logic [7:0] sel, input drive_io_pkg::monitor_t m,
                                        input logic vec, input logic sens);
    logic [15:0] mag;
    mag = m.torque[15] ? 16'(-m.torque) : m.torque;
    case (sel)
      drive_io_pkg::MON_FREQ, drive_io_pkg::MON_DIG_FREQ:
        level = sens ? m.shaft_freq : m.out_freq;
      drive_io_pkg::MON_CUR: level = m.current;
      drive_io_pkg::MON_TORQUE: level = vec ? mag : 16'h0000;
      drive_io_pkg::MON_OUT_VOLT: level = m.out_volt;
      drive_io_pkg::MON_IN_VOLT: level = m.in_volt;
      drive_io_pkg::MON_THERMAL: level = m.thermal;
      drive_io_pkg::MON_RAMP: level = m.ramp_freq;
      drive_io_pkg::MON_CUR_PULSE: level = m.current_amps;
      drive_io_pkg::MON_MOTOR_TEMP: level = temp_level(m.motor_temp);
      drive_io_pkg::MON_FIN_TEMP: level = temp_level(m.fin_temp);
      drive_io_pkg::MON_SIGNED_TORQUE:
        level = vec ? (m.torque ^ 16'h8000) : 16'h0000;
      default: level = 16'h0000;
    endcase
  endfunction
  // gain in percent, then offset in percent of full scale
  function automatic logic [15:0] scale(input logic [15:0] v, input logic [7:0] gain,
                                        input logic [7:0] ofs);
    logic [31:0] p;
    logic [15:0] g;
    p = (32'(v) * 32'(gain)) / 32'd100;
    g = (p > 32'h0000FFFF) ? 16'hFFFF : p[15:0];
    p = (32'(g) * 32'(8'd100 - ofs)) / 32'd100 + 32'(ofs) * 32'd655;
    scale = (p > 32'h0000FFFF) ? 16'hFFFF : p[15:0];
  endfunction
  // apb slave, zero wait states
  assign hit = (i_paddr[1:0] == 2'b00) && (i_paddr <= `DTIO_OFS_STATUS);
  assign wr = i_psel && i_penable && i_pwrite && hit;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !hit;
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      for (int i = 0; i < N_OUT; i++) begin
        out_sel[i] <= (i == N_OUT - 1) ? `DTIO_RST_RELAYSEL : `DTIO_RST_OUTSEL;
        dly[i] <= '0;
      end
      for (int i = 0; i < N_IN; i++) resp[i] <= `DTIO_RST_RESP;
      pmon_sel <= 8'h00;
      pmon_gain <= `DTIO_RST_GAIN;
      vmon_sel <= 8'h00;
      imon_sel <= 8'h00;
      vmon_gain <= `DTIO_RST_GAIN;
      imon_gain <= `DTIO_RST_GAIN;
      vmon_ofs <= `DTIO_RST_VOFS;
      imon_ofs <= `DTIO_RST_IOFS;
      cur_ref <= RATED_CURRENT;
      ctrl_method <= 8'h00;
    end else if (wr) begin
      for (int i = 0; i < N_OUT; i++) begin
        if (i_paddr == 8'(`DTIO_OFS_OUTSEL + 4 * i)) out_sel[i] <= i_pwdata[7:0];
        if (i_paddr == 8'(`DTIO_OFS_DELAY + 4 * i)) begin
          dly[i].on_dly <= 10'(clamp16(16'(i_pwdata[`DTIO_DELAY_ON_LSB +: 10]), 16'h0000,
                                       16'(`DTIO_DELAY_MAX)));
          dly[i].off_dly <= 10'(clamp16(16'(i_pwdata[`DTIO_DELAY_OFF_LSB +: 10]), 16'h0000,
                                        16'(`DTIO_DELAY_MAX)));
        end
      end
      for (int i = 0; i < N_IN; i++) begin
        if (i_paddr == 8'(`DTIO_OFS_RESP + 4 * i))
          resp[i] <= 8'(clamp16({8'h00, i_pwdata[7:0]}, 16'h0000, 16'(`DTIO_RESP_MAX)));
      end
      case (i_paddr)
        `DTIO_OFS_PMON_SEL: pmon_sel <= i_pwdata[7:0];
        `DTIO_OFS_PMON_GAIN:
          pmon_gain <= 8'(clamp16({8'h00, i_pwdata[7:0]}, 16'(`DTIO_GAIN_MIN),
                                  16'(`DTIO_GAIN_MAX)));
        `DTIO_OFS_VMON_SEL: vmon_sel <= i_pwdata[7:0];
        `DTIO_OFS_IMON_SEL: imon_sel <= i_pwdata[7:0];
        `DTIO_OFS_VMON_GAIN:
          vmon_gain <= 8'(clamp16({8'h00, i_pwdata[7:0]}, 16'(`DTIO_GAIN_MIN),
                                  16'(`DTIO_GAIN_MAX)));
        `DTIO_OFS_IMON_GAIN:
          imon_gain <= 8'(clamp16({8'h00, i_pwdata[7:0]}, 16'(`DTIO_GAIN_MIN),
                                  16'(`DTIO_GAIN_MAX)));
        `DTIO_OFS_VMON_OFS:
          vmon_ofs <= 8'(clamp16({8'h00, i_pwdata[7:0]}, 16'h0000, 16'(`DTIO_OFS_MAX)));
        `DTIO_OFS_IMON_OFS:
          imon_ofs <= 8'(clamp16({8'h00, i_pwdata[7:0]}, 16'h0000, 16'(`DTIO_OFS_MAX)));
        `DTIO_OFS_CUR_REF: cur_ref <= clamp16(i_pwdata[15:0], REF_MIN, REF_MAX);
        `DTIO_OFS_CTRL_METHOD: ctrl_method <= i_pwdata[7:0];
        default: ;
      endcase
    end
  end
  // read data is captured in the setup phase
  always_comb begin
    next_rdata = 32'h00000000;
    for (int i = 0; i < N_OUT; i++) begin
      if (i_paddr == 8'(`DTIO_OFS_OUTSEL + 4 * i)) next_rdata = {24'h000000, out_sel[i]};
      if (i_paddr == 8'(`DTIO_OFS_DELAY + 4 * i))
        next_rdata = {6'h00, dly[i].off_dly, 6'h00, dly[i].on_dly};
    end
    for (int i = 0; i < N_IN; i++) begin
      if (i_paddr == 8'(`DTIO_OFS_RESP + 4 * i)) next_rdata = {24'h000000, resp[i]};
    end
    case (i_paddr)
      `DTIO_OFS_PMON_SEL: next_rdata = {24'h000000, pmon_sel};
      `DTIO_OFS_PMON_GAIN: next_rdata = {24'h000000, pmon_gain};
      `DTIO_OFS_VMON_SEL: next_rdata = {24'h000000, vmon_sel};
      `DTIO_OFS_IMON_SEL: next_rdata = {24'h000000, imon_sel};
      `DTIO_OFS_VMON_GAIN: next_rdata = {24'h000000, vmon_gain};
      `DTIO_OFS_IMON_GAIN: next_rdata = {24'h000000, imon_gain};
      `DTIO_OFS_VMON_OFS: next_rdata = {24'h000000, vmon_ofs};
      `DTIO_OFS_IMON_OFS: next_rdata = {24'h000000, imon_ofs};
      `DTIO_OFS_CUR_REF: next_rdata = {16'h0000, cur_ref};
      `DTIO_OFS_CTRL_METHOD: next_rdata = {24'h000000, ctrl_method};
      `DTIO_OFS_STATUS:
        next_rdata = {7'h00, o_filtered_inputs, 10'h000, term};
      default: ;
    endcase
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) o_prdata <= 32'h00000000;
    else if (i_psel && !i_penable && !i_pwrite) o_prdata <= next_rdata;
  end
  // time bases: 100 ms for output delays, 2 ms for input sampling
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || delay_tick) delay_tick_cnt <= 32'h00000000;
    else delay_tick_cnt <= delay_tick_cnt + 32'h00000001;
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || resp_tick) resp_tick_cnt <= 32'h00000000;
    else resp_tick_cnt <= resp_tick_cnt + 32'h00000001;
  end
  assign delay_tick = (delay_tick_cnt == 32'(DELAY_TICK_CYC - 1));
  assign resp_tick = (resp_tick_cnt == 32'(RESP_TICK_CYC - 1));
  // output conditions
  assign fatal = i_alarm || (|i_hw_trip);
  assign vec_mode = (ctrl_method == `DTIO_CM_SLV) || (ctrl_method == `DTIO_CM_ZSLV) ||
                    (ctrl_method == `DTIO_CM_V2);
  assign sens_mode = (ctrl_method == `DTIO_CM_V2);
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_reverse_run_indicator <= 1'b0;
      o_fatal_fault_indicator <= 1'b0;
    end else begin
      o_reverse_run_indicator <= i_run_reverse;
      o_fatal_fault_indicator <= fatal;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N_OUT; g++) begin : g_out
      logic [9:0] cnt;
      logic [9:0] lim;
      always_comb begin
        if (out_sel[g] == `DTIO_FN_REVERSE) cond[g] = i_run_reverse;
        else if (out_sel[g] == `DTIO_FN_FATAL) cond[g] = fatal;
        else cond[g] = (out_sel[g] < 8'h40) ? i_out_cond[out_sel[g][5:0]] : 1'b0;
      end
      assign lim = cond[g] ? dly[g].on_dly : dly[g].off_dly;
      always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
          term[g] <= 1'b0;
          cnt <= 10'h000;
        end else if (cond[g] == term[g]) begin
          cnt <= 10'h000;
        end else if (lim == 10'h000 || (delay_tick && cnt + 10'h001 >= lim)) begin
          term[g] <= cond[g];
          cnt <= 10'h000;
        end else if (delay_tick) begin
          cnt <= cnt + 10'h001;
        end
      end
    end
    assign raw_in = {i_forward_run_input, i_multi_function_inputs};
    for (g = 0; g < N_IN; g++) begin : g_in
      logic [7:0] cnt;
      logic prev;
      logic [7:0] need;
      assign need = (resp[g] == 8'h00) ? 8'h01 : resp[g];
      always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
          o_filtered_inputs[g] <= 1'b0;
          prev <= 1'b0;
          cnt <= 8'h00;
        end else begin
          prev <= raw_in[g];
          if (raw_in[g] == o_filtered_inputs[g] || raw_in[g] != prev) begin
            cnt <= 8'h00;
          end else if (resp_tick) begin
            if (cnt + 8'h01 >= need) begin
              o_filtered_inputs[g] <= raw_in[g];
              cnt <= 8'h00;
            end else begin
              cnt <= cnt + 8'h01;
            end
          end
        end
      end
    end
  endgenerate
  assign o_open_collector_outputs = term[4:0];
  assign o_relay_output = term[5];

  // pulse monitor: nco for digital modes, pwm for a meter
  logic [15:0] pm_lvl;
  logic [31:0] acc, acc_lim;
  logic [9:0] pwm_cnt;
  logic pm_digital, pm_tog;
  assign pm_lvl = scale(level(pmon_sel, i_monitor, vec_mode, sens_mode), pmon_gain, 8'h00);
  assign pm_digital = (pmon_sel == drive_io_pkg::MON_DIG_FREQ) ||
                      (pmon_sel == drive_io_pkg::MON_CUR_PULSE);
  assign acc_lim = ((pmon_sel == drive_io_pkg::MON_CUR_PULSE) ? 32'(cur_ref) : 32'h0000FFFF) *
                   32'(HALF_CYC);
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || !pm_digital) begin
      acc <= 32'h00000000;
      pm_tog <= 1'b0;
    end else if (acc + 32'(pm_lvl) >= acc_lim) begin
      acc <= acc + 32'(pm_lvl) - acc_lim;
      pm_tog <= !pm_tog;
    end else begin
      acc <= acc + 32'(pm_lvl);
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      pwm_cnt <= 10'h000;
      o_pulse_monitor_terminal <= 1'b0;
    end else begin
      pwm_cnt <= pwm_cnt + 10'h001;
      o_pulse_monitor_terminal <= pm_digital ? pm_tog : (pwm_cnt < pm_lvl[15:6]);
    end
  end

  // analog monitors
  logic v_ok, i_ok;
  assign v_ok = (vmon_sel != drive_io_pkg::MON_DIG_FREQ) &&
                (vmon_sel != drive_io_pkg::MON_CUR_PULSE);
  assign i_ok = (imon_sel != drive_io_pkg::MON_SIGNED_TORQUE) &&
                (imon_sel != drive_io_pkg::MON_DIG_FREQ) &&
                (imon_sel != drive_io_pkg::MON_CUR_PULSE);
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_voltage_monitor_output <= 16'h0000;
      o_current_monitor_output <= 16'h0000;
    end else begin
      o_voltage_monitor_output <= scale(v_ok ? level(vmon_sel, i_monitor, vec_mode, sens_mode) :
                                        16'h0000, vmon_gain, vmon_ofs);
      o_current_monitor_output <= scale(i_ok ? level(imon_sel, i_monitor, vec_mode, sens_mode) :
                                        16'h0000, imon_gain, imon_ofs);
    end
  end

  property p_rev_zero_delay;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (out_sel[0] == `DTIO_FN_REVERSE && dly[0].on_dly == 10'h000 && i_run_reverse &&
     !term[0]) |=> term[0];
  endproperty
  a_rev_zero_delay: assert property (p_rev_zero_delay) else $error("reverse output late");
  property p_alarm_out;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (out_sel[1] == `DTIO_FN_FATAL && dly[1].on_dly == 10'h000 && i_alarm) |=> term[1];
  endproperty
  a_alarm_out: assert property (p_alarm_out) else $error("alarm output missing");
  property p_hw_trip;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (|i_hw_trip) |=> o_fatal_fault_indicator;
  endproperty
  a_hw_trip: assert property (p_hw_trip) else $error("fatal indicator missed trip");
  property p_relay_default;
    @(posedge i_sys_clk) $past(i_sys_rst) && !i_sys_rst |-> out_sel[N_OUT-1] == 8'h05;
  endproperty
  a_relay_default: assert property (p_relay_default) else $error("relay select default");
  property p_on_hold;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (!term[2] && cond[2] && dly[2].on_dly != 10'h000 && !delay_tick) |=> !term[2];
  endproperty
  a_on_hold: assert property (p_on_hold) else $error("on-delay not honoured");
  property p_off_hold;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (term[2] && !cond[2] && dly[2].off_dly != 10'h000 && !delay_tick) |=> term[2];
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("off-delay not honoured");
  property p_in_tick;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    $changed(o_filtered_inputs) |-> $past(resp_tick) &&
      ((o_filtered_inputs ^ $past(o_filtered_inputs)) & (o_filtered_inputs ^ $past(raw_in))) == '0;
  endproperty
  a_in_tick: assert property (p_in_tick) else $error("input accepted off tick");
  property p_cold;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (vmon_sel == drive_io_pkg::MON_MOTOR_TEMP && i_monitor.motor_temp[15] &&
     vmon_ofs == 8'h00) |=> o_voltage_monitor_output == 16'h0000;
  endproperty
  a_cold: assert property (p_cold) else $error("negative temperature not zero");
  property p_torque_gate;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (vmon_sel == drive_io_pkg::MON_TORQUE && !vec_mode && vmon_ofs == 8'h00)
    |=> o_voltage_monitor_output == 16'h0000;
  endproperty
  a_torque_gate: assert property (p_torque_gate) else $error("torque shown without vector");
  c_delayed_on: cover property (@(posedge i_sys_clk) !term[2] && delay_tick ##1 term[2]);
  c_input_accept: cover property (@(posedge i_sys_clk) $changed(o_filtered_inputs[0]));
  c_pulse_toggle: cover property (@(posedge i_sys_clk) pm_digital && $changed(pm_tog));
endmodule

// [verif/field_io_model.sv]
// field switches and loads at the terminals
`timescale 1ns/1ns
module field_io_model (
  // clock
  input wire logic i_sys_clk,
  // commanded switch levels and contact bounce
  input wire logic [8:0] i_want,
  input wire logic i_bounce,
  // terminal outputs seen by the lamps
  input wire logic [5:0] i_terminals,
  output logic [8:0] o_switches,
  output logic [5:0] o_lamps
);
  // a bouncing contact flips every cycle, so the filter must never settle
  always @(posedge i_sys_clk) begin
    o_switches <= i_bounce ? ~o_switches : i_want;
    o_lamps <= i_terminals;
  end
endmodule

// [verif/tb.sv]
// self-checking bench for the terminal conditioning block
`timescale 1ns/1ns
module tb;
  logic i_sys_clk = 0, i_sys_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, rd, o_prdata;
  logic o_pready, o_pslverr, err, rly, rev, fat, pm, bounce = 0, run_rev = 0, alarm = 0;
  logic [5:0] trip = 6'h00, term;
  logic [63:0] cond = 64'h0;
  drive_io_pkg::monitor_t mon = '0;
  logic [8:0] want = 9'h000, sw, filt;
  logic [4:0] oc;
  logic [15:0] vmon, imon;
  logic [7:0] code [6];
  logic [5:0] ex;
  int failures = 0, comparisons = 0, seed = 86122, cyc = 0, n;
  localparam logic [7:0] RA [8] = '{8'h14, 8'h18, 8'h30, 8'h58, 8'h5C, 8'h64, 8'h6C, 8'h70};
  localparam logic [7:0] RV [8] = '{8'h05, 8'h00, 8'h01, 8'h64, 8'h00, 8'h64, 8'h00, 8'h14};
  assign term = {rly, oc};
  always #25 i_sys_clk = ~i_sys_clk;
  drive_terminal_io_conditioning #(.DELAY_TICK_CYC(20), .RESP_TICK_CYC(8)) uut (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_prdata(o_prdata), .i_run_reverse(run_rev), .i_alarm(alarm),
    .i_hw_trip(trip), .i_out_cond(cond), .i_monitor(mon),
    .i_multi_function_inputs(sw[7:0]), .i_forward_run_input(sw[8]),
    .o_filtered_inputs(filt), .o_open_collector_outputs(oc), .o_relay_output(rly),
    .o_reverse_run_indicator(rev), .o_fatal_fault_indicator(fat),
    .o_pulse_monitor_terminal(pm), .o_voltage_monitor_output(vmon),
    .o_current_monitor_output(imon));
  field_io_model field (.i_sys_clk(i_sys_clk), .i_want(want), .i_bounce(bounce),
    .i_terminals(term), .o_switches(sw), .o_lamps());
  task automatic stop_test();
    if (failures == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      stop_test();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_psel <= 1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_sys_clk);
    i_penable <= 1;
    do @(posedge i_sys_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 0;
    i_penable <= 0;
  endtask
  task automatic settle();
    repeat (3) @(posedge i_sys_clk);
  endtask
  function automatic logic [15:0] mexp(input logic [15:0] lvl, input int g, input int ofs);
    int v;
    v = lvl * g / 100;
    if (v > 65535) v = 65535;
    return 16'(v * (100 - ofs) / 100 + ofs * 655);
  endfunction
  initial begin
    repeat (12) @(posedge i_sys_clk);
    i_sys_rst <= 0;
    repeat (2) @(posedge i_sys_clk);
    chk("imon_reset", 32'(16'h332C), imon);
    for (int i = 0; i < 8; i++) begin
      apb(0, RA[i], 32'h0);
      chk("reset_value", RV[i], rd);
    end
    apb(0, 8'h80, 32'h0);
    chk("bad_addr_err", 1, err);
    // random function codes below 32, zero delay on every output
    for (int i = 0; i < 6; i++) begin
      code[i] = 8'($random(seed) & 31);
      apb(1, 8'(4 * i), code[i]);
    end
    repeat (20) begin
      @(posedge i_sys_clk);
      cond <= {$random(seed), $random(seed)};
      repeat (2) @(posedge i_sys_clk);
      for (int i = 0; i < 6; i++) ex[i] = cond[code[i]];
      chk("zero_delay", ex, term);
    end
    cond <= 64'h0;
    apb(1, 8'h00, 8'h34);
    apb(1, 8'h04, 8'h35);
    for (int v = 1; v >= 0; v--) begin
      run_rev <= v[0];
      settle();
      chk("reverse", {2{v[0]}}, {term[0], rev});
    end
    for (int k = 0; k < 7; k++) begin
      trip <= (k < 6) ? 6'(1 << k) : 6'h00;
      alarm <= (k == 6);
      settle();
      chk("fatal_on", 2'b11, {term[1], fat});
      trip <= 6'h00;
      alarm <= 0;
      settle();
      chk("fatal_off", 2'b00, {term[1], fat});
    end
    apb(1, 8'h08, 8'h07);
    apb(1, 8'h20, 32'h0003_0002);
    cond <= 64'h80;
    repeat (10) @(posedge i_sys_clk);
    cond <= 64'h0;
    repeat (60) @(posedge i_sys_clk);
    chk("on_abort", 0, term[2]);
    cond <= 64'h80;
    repeat (18) @(posedge i_sys_clk);
    chk("on_early", 0, term[2]);
    repeat (24) @(posedge i_sys_clk);
    chk("on_done", 1, term[2]);
    cond <= 64'h0;
    repeat (38) @(posedge i_sys_clk);
    chk("off_hold", 1, term[2]);
    repeat (26) @(posedge i_sys_clk);
    chk("off_done", 0, term[2]);
    apb(1, 8'h30, 32'h3);
    want <= 9'h101;
    repeat (14) @(posedge i_sys_clk);
    chk("in_early", 0, filt[0]);
    repeat (16) @(posedge i_sys_clk);
    chk("in_taken", 2'b11, {filt[8], filt[0]});
    bounce <= 1;
    want <= 9'h000;
    repeat (40) @(posedge i_sys_clk);
    chk("in_bounce", 1, filt[0]);
    bounce <= 0;
    repeat (30) @(posedge i_sys_clk);
    chk("in_release", 0, filt[0]);
    mon.out_freq <= 16'h8000;
    mon.shaft_freq <= 16'h1234;
    mon.motor_temp <= 16'hFFFB;
    mon.torque <= 16'h4000;
    mon.current_amps <= 16'h0064;
    apb(1, 8'h64, 32'hC8);
    settle();
    chk("vmon_gain", mexp(16'h8000, 200, 0), vmon);
    chk("imon_ofs", mexp(16'h8000, 100, 20), imon);
    apb(1, 8'h78, 32'h5);
    settle();
    chk("vmon_shaft", mexp(16'h1234, 200, 0), vmon);
    apb(1, 8'h64, 32'h64);
    apb(1, 8'h5C, 32'h9);
    settle();
    chk("temp_cold", 0, vmon);
    mon.motor_temp <= 16'h0064;
    settle();
    chk("temp_hot", mexp(16'h7FBC, 100, 0), vmon);
    apb(1, 8'h78, 32'h0);
    apb(1, 8'h5C, 32'h2);
    apb(1, 8'h60, 32'hB);
    settle();
    chk("torque_vf", 0, vmon);
    chk("imon_signed", mexp(16'h0000, 100, 20), imon);
    apb(1, 8'h5C, 32'h8);
    apb(1, 8'h60, 32'h0);
    settle();
    chk("vmon_cur_pulse", 0, vmon);
    chk("imon_beside", mexp(16'h8000, 100, 20), imon);
    apb(1, 8'h54, 32'h8);
    settle();
    @(posedge pm);
    n = cyc;
    @(posedge pm);
    chk("pulse_1440", 1, 32'((cyc - n) inside {[13886:13890]}));
    stop_test();
  end
endmodule
